// ### hdl/misc_pins.sv
`timescale 1ns/10ps
`default_nettype none
`include "misc_pins_map.svh"

module misc_pins
#(
	parameter logic [`CYCLE_CNT_W-1:0] CYCLE_PERIOD =
		`CYCLE_CNT_W'(`CYCLE_PERIOD_CNT)
)
(
	// Clock and host bus reset
	input  wire logic       CLOCK,
	input  wire logic       SRST,
	// Global reset pin
	input  wire logic       GLOBAL_RST,
	// Cycle timer pins and control
	input  wire logic       CYCLE_SYNC_IN,
	input  wire logic       CYCLE_EXT_SEL,
	input  wire logic       CYCLE_OUT_EN,
	output logic            CYCLE_TICK,
	// Shared strap and cycle sync pin
	input  wire logic       CARD_MODE_STRAP_I,
	output logic            CYCLE_SYNC_OUT_O,
	output logic            CYCLE_SYNC_OUT_OE,
	output logic            CARD_MODE,
	// General I/O 2
	input  wire logic       GENERAL_IO_2_I,
	output logic            GENERAL_IO_2_O,
	output logic            GENERAL_IO_2_OE,
	input  wire logic       GENERAL_IO_2_DIR,
	input  wire logic       GENERAL_IO_2_DATA,
	output logic            GENERAL_IO_2_LEVEL,
	// General I/O 3
	input  wire logic       GENERAL_IO_3_I,
	output logic            GENERAL_IO_3_O,
	output logic            GENERAL_IO_3_OE,
	input  wire logic       GENERAL_IO_3_DIR,
	input  wire logic       GENERAL_IO_3_DATA,
	output logic            GENERAL_IO_3_LEVEL,
	// Two-wire ROM pins
	output logic            SCL_O,
	output logic            SCL_OE,
	input  wire logic       SDA_I,
	output logic            SDA_O,
	output logic            SDA_OE,
	// ROM command port
	input  wire logic       ROM_CMD_VALID,
	input  wire logic [1:0] ROM_CMD,
	input  wire logic [7:0] ROM_WDATA,
	input  wire logic       ROM_ACK_OUT,
	output logic            ROM_BUSY,
	output logic            ROM_DONE,
	output logic [7:0]      ROM_RDATA,
	output logic            ROM_ACK_IN,
	output logic            ROM_PRESENT
);

	localparam logic [`CYCLE_CNT_W-1:0] PERIOD_LAST =
		`CYCLE_CNT_W'(CYCLE_PERIOD - 1'b1);
	localparam logic [`CYCLE_CNT_W-1:0] PERIOD_HALF =
		`CYCLE_CNT_W'(CYCLE_PERIOD >> 1);

	misc_pins_pkg::misc_state_type q_q;
	misc_pins_pkg::misc_state_type q_d;

	logic cin_rise;

	always_comb
	begin
		q_d = q_q;
		// Two-flop synchronisers for every pin input
		q_d.grst_s1 = GLOBAL_RST;
		q_d.grst_s2 = q_q.grst_s1;
		q_d.strap_s1 = CARD_MODE_STRAP_I;
		q_d.strap_s2 = q_q.strap_s1;
		q_d.cin_s1 = CYCLE_SYNC_IN;
		q_d.cin_s2 = q_q.cin_s1;
		q_d.cin_s3 = q_q.cin_s2;
		q_d.sda_s1 = SDA_I;
		q_d.sda_s2 = q_q.sda_s1;
		q_d.gio_s1 = {GENERAL_IO_3_I, GENERAL_IO_2_I};
		q_d.gio_s2 = q_q.gio_s1;
		cin_rise = q_q.cin_s2 & ~q_q.cin_s3;

		// Strap follows the pin for as long as global reset holds
		if (q_q.grst_s2)
			q_d.card_mode = q_q.strap_s2;

		// Free-running fallback keeps the sync alive if the input stops
		q_d.tick = 1'b0;
		if (CYCLE_EXT_SEL && cin_rise)
		begin
			q_d.cnt = `CYCLE_CNT_W'(0);
			q_d.tick = 1'b1;
		end
		else if (q_q.cnt >= PERIOD_LAST)
		begin
			q_d.cnt = `CYCLE_CNT_W'(0);
			q_d.tick = 1'b1;
		end
		else
			q_d.cnt = `CYCLE_CNT_W'(q_q.cnt + 1'b1);
		q_d.sync_out = (q_d.cnt < PERIOD_HALF);
		// Never drive against the card-mode pulldown
		q_d.sync_oe = CYCLE_OUT_EN & q_q.card_mode &
			~q_q.grst_s2;

		q_d.gio_oe = {GENERAL_IO_3_DIR, GENERAL_IO_2_DIR};
		q_d.gio_o = {GENERAL_IO_3_DATA, GENERAL_IO_2_DATA};
		q_d.scl_o = 1'b0;
		q_d.sda_o = 1'b0;

		if (SRST)
		begin
			q_d.rom_present = q_q.sda_s2;
			q_d.cnt = `CYCLE_CNT_W'(0);
			q_d.tick = 1'b0;
			q_d.sync_out = 1'b0;
			q_d.sync_oe = 1'b0;
			q_d.gio_oe = 2'h0;
			q_d.gio_o = 2'h0;
		end
	end

	always_ff @(posedge CLOCK)
		q_q <= q_d;

	rom_link u_rom_link
	(
		.clock     (CLOCK),
		.srst      (SRST),
		.enable    (q_q.rom_present),
		.cmd_valid (ROM_CMD_VALID),
		.cmd       (ROM_CMD),
		.wdata     (ROM_WDATA),
		.ack_out   (ROM_ACK_OUT),
		.busy      (ROM_BUSY),
		.done      (ROM_DONE),
		.rdata     (ROM_RDATA),
		.ack_in    (ROM_ACK_IN),
		.sda_level (q_q.sda_s2),
		.scl_oe    (SCL_OE),
		.sda_oe    (SDA_OE)
	);

	assign CYCLE_TICK = q_q.tick;
	assign CYCLE_SYNC_OUT_O = q_q.sync_out;
	assign CYCLE_SYNC_OUT_OE = q_q.sync_oe;
	assign CARD_MODE = q_q.card_mode;
	assign GENERAL_IO_2_O = q_q.gio_o[0];
	assign GENERAL_IO_2_OE = q_q.gio_oe[0];
	assign GENERAL_IO_2_LEVEL = q_q.gio_s2[0];
	assign GENERAL_IO_3_O = q_q.gio_o[1];
	assign GENERAL_IO_3_OE = q_q.gio_oe[1];
	assign GENERAL_IO_3_LEVEL = q_q.gio_s2[1];
	assign SCL_O = q_q.scl_o;
	assign SDA_O = q_q.sda_o;
	assign ROM_PRESENT = q_q.rom_present;

	a_ext_cycle_lock: assert property (
		@(posedge CLOCK) disable iff (SRST)
		CYCLE_EXT_SEL && q_q.cin_s2 && !q_q.cin_s3
		|=> q_q.cnt == `CYCLE_CNT_W'(0) && CYCLE_TICK)
		else $error("cycle timer missed external edge");

	a_strap_hold: assert property (
		@(posedge CLOCK)
		!q_q.grst_s2 |=> $stable(CARD_MODE))
		else $error("card mode changed outside global reset");

	a_sync_out_off: assert property (
		@(posedge CLOCK)
		q_q.grst_s2 |=> !CYCLE_SYNC_OUT_OE)
		else $error("cycle sync driven during global reset");

	a_tick_spacing: assert property (
		@(posedge CLOCK) disable iff (SRST)
		!CYCLE_EXT_SEL && CYCLE_TICK |=> (!CYCLE_TICK)[*8])
		else $error("cycle ticks too close");

	a_io_input_reset: assert property (
		@(posedge CLOCK)
		SRST |=> !GENERAL_IO_2_OE && !GENERAL_IO_3_OE)
		else $error("general io driver on after reset");

	a_rom_detect: assert property (
		@(posedge CLOCK)
		$fell(SRST) |-> ROM_PRESENT == $past(q_q.sda_s2))
		else $error("rom presence not from reset level");

	a_sda_open_drain: assert property (
		@(posedge CLOCK) disable iff (SRST)
		SDA_OE |-> ROM_PRESENT && !SDA_O)
		else $error("data line misuse");

	a_scl_open_drain: assert property (
		@(posedge CLOCK) disable iff (SRST)
		!SCL_O && (!SCL_OE || ROM_PRESENT))
		else $error("serial clock driven high or without rom");

	a_no_rom_quiet: assert property (
		@(posedge CLOCK) disable iff (SRST)
		!ROM_PRESENT ##1 ROM_CMD_VALID |=> !ROM_BUSY && !SCL_OE && !SDA_OE)
		else $error("rom activity without rom");

	a_no_rom_lines: assert property (
		@(posedge CLOCK) disable iff (SRST)
		!ROM_PRESENT |-> !SCL_OE && !SDA_OE && !ROM_BUSY)
		else $error("rom lines active without rom");

	a_tick_sync_high: assert property (
		@(posedge CLOCK) disable iff (SRST)
		CYCLE_TICK |-> CYCLE_SYNC_OUT_O)
		else $error("cycle sync low at tick");

	a_io_follow_dir: assert property (
		@(posedge CLOCK)
		!SRST |=> GENERAL_IO_2_OE == $past(GENERAL_IO_2_DIR)
			&& GENERAL_IO_3_OE == $past(GENERAL_IO_3_DIR))
		else $error("general io driver not under control");

	a_strap_capture: assert property (
		@(posedge CLOCK)
		q_q.grst_s2 |=> CARD_MODE == $past(q_q.strap_s2))
		else $error("card mode not taken from strap");

endmodule

`default_nettype wire

// ### hdl/misc_pins_map.svh
`ifndef MISC_PINS_MAP_SVH
`define MISC_PINS_MAP_SVH

// Core clock rate
`define CLOCK_MHZ 250

// Cycle timer: 8 kHz reference, 125 us period
`define CYCLE_PERIOD_NS 125000
`define CYCLE_PERIOD_CNT ((`CYCLE_PERIOD_NS * `CLOCK_MHZ) / 1000)
`define CYCLE_CNT_W 15

// Two-wire link: quarter of a 10 us bit time, rounded up
`define ROM_QUARTER_NS 2500
`define ROM_QUARTER_CNT ((`ROM_QUARTER_NS * `CLOCK_MHZ + 999) / 1000)
`define ROM_TICK_W 10

// Bit index of the acknowledge slot within a byte
`define ROM_ACK_BIT 4'h8

// Reset values and general I/O count
`define CARD_MODE_RESET 1'b1
`define IO_COUNT 2

`endif

// ### hdl/misc_pins_pkg.sv
`default_nettype none
`include "misc_pins_map.svh"

package misc_pins_pkg;

	typedef enum logic [1:0] {
		CMD_START,
		CMD_STOP,
		CMD_WRITE,
		CMD_READ
	} rom_cmd_type;

	typedef enum logic [1:0] {
		RL_IDLE,
		RL_START,
		RL_STOP,
		RL_BITS
	} rom_phase_type;

	typedef struct packed {
		rom_phase_type           state;
		logic [1:0]              qtr;
		logic [`ROM_TICK_W-1:0]  tick;
		logic [3:0]              bitn;
		logic [7:0]              shift;
		logic                    read;
		logic                    ack_send;
		logic                    scl_oe;
		logic                    sda_oe;
		logic                    busy;
		logic                    done;
		logic                    ack_in;
		logic [7:0]              rdata;
	} rom_link_state_type;

	typedef struct packed {
		logic                    grst_s1;
		logic                    grst_s2;
		logic                    strap_s1;
		logic                    strap_s2;
		logic                    cin_s1;
		logic                    cin_s2;
		logic                    cin_s3;
		logic                    sda_s1;
		logic                    sda_s2;
		logic [`IO_COUNT-1:0]    gio_s1;
		logic [`IO_COUNT-1:0]    gio_s2;
		logic                    card_mode;
		logic                    rom_present;
		logic [`CYCLE_CNT_W-1:0] cnt;
		logic                    tick;
		logic                    sync_out;
		logic                    sync_oe;
		logic [`IO_COUNT-1:0]    gio_oe;
		logic [`IO_COUNT-1:0]    gio_o;
		logic                    scl_o;
		logic                    sda_o;
	} misc_state_type;

endpackage

`default_nettype wire

// ### hdl/rom_link.sv
`timescale 1ns/10ps
`default_nettype none
`include "misc_pins_map.svh"

module rom_link
(
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       srst,
	// Command side
	input  wire logic       enable,
	input  wire logic       cmd_valid,
	input  wire logic [1:0] cmd,
	input  wire logic [7:0] wdata,
	input  wire logic       ack_out,
	output logic            busy,
	output logic            done,
	output logic [7:0]      rdata,
	output logic            ack_in,
	// Two-wire line side
	input  wire logic       sda_level,
	output logic            scl_oe,
	output logic            sda_oe
);

	localparam logic [`ROM_TICK_W-1:0] QTR_LAST =
		`ROM_TICK_W'(`ROM_QUARTER_CNT - 1);

	misc_pins_pkg::rom_link_state_type q_q;
	misc_pins_pkg::rom_link_state_type q_d;

	// Data line pull for bit n: high means pull low
	function automatic logic bit_pull
	(
		input logic       rd,
		input logic [3:0] n,
		input logic [7:0] sh,
		input logic       ak
	);
		if (n == `ROM_ACK_BIT)
			bit_pull = rd & ak;
		else
			bit_pull = ~rd & ~sh[7];
	endfunction

	always_comb
	begin
		q_d = q_q;
		q_d.done = 1'b0;
		if (q_q.state == misc_pins_pkg::RL_IDLE)
		begin
			if (cmd_valid)
			begin
				q_d.qtr = 2'h0;
				q_d.tick = `ROM_TICK_W'(0);
				case (misc_pins_pkg::rom_cmd_type'(cmd))
				misc_pins_pkg::CMD_START:
				begin
					q_d.state = misc_pins_pkg::RL_START;
					q_d.scl_oe = 1'b0;
					q_d.sda_oe = 1'b0;
				end
				misc_pins_pkg::CMD_STOP:
				begin
					q_d.state = misc_pins_pkg::RL_STOP;
					q_d.scl_oe = 1'b1;
					q_d.sda_oe = 1'b1;
				end
				default:
				begin
					q_d.state = misc_pins_pkg::RL_BITS;
					q_d.bitn = 4'h0;
					q_d.read = (cmd == misc_pins_pkg::CMD_READ);
					q_d.ack_send = ack_out;
					q_d.shift = wdata;
					q_d.scl_oe = 1'b1;
					q_d.sda_oe = bit_pull(q_d.read, 4'h0, wdata,
						ack_out);
				end
				endcase
			end
		end
		else if (q_q.tick != QTR_LAST)
			q_d.tick = `ROM_TICK_W'(q_q.tick + 1'b1);
		else
		begin
			q_d.tick = `ROM_TICK_W'(0);
			q_d.qtr = q_q.qtr + 2'h1;
			case (q_q.state)
			misc_pins_pkg::RL_START:
			begin
				// Data falls while the clock is high
				if (q_q.qtr == 2'h1)
					q_d.sda_oe = 1'b1;
				if (q_q.qtr == 2'h2)
					q_d.scl_oe = 1'b1;
			end
			misc_pins_pkg::RL_STOP:
			begin
				if (q_q.qtr == 2'h0)
					q_d.scl_oe = 1'b0;
				if (q_q.qtr == 2'h1)
					q_d.sda_oe = 1'b0;
			end
			default:
			begin
				if (q_q.qtr == 2'h0)
					q_d.scl_oe = 1'b0;
				if (q_q.qtr == 2'h1)
				begin
					if (q_q.bitn == `ROM_ACK_BIT)
						q_d.ack_in = ~sda_level;
					else
						q_d.shift = {q_q.shift[6:0], sda_level};
				end
				if (q_q.qtr == 2'h2)
					q_d.scl_oe = 1'b1;
			end
			endcase
			if (q_q.qtr == 2'h3)
			begin
				if (q_q.state == misc_pins_pkg::RL_BITS &&
					q_q.bitn != `ROM_ACK_BIT)
				begin
					q_d.bitn = q_q.bitn + 4'h1;
					q_d.sda_oe = bit_pull(q_q.read, q_d.bitn,
						q_d.shift, q_q.ack_send);
				end
				else
				begin
					if (q_q.state == misc_pins_pkg::RL_BITS)
						q_d.rdata = q_q.shift;
					q_d.state = misc_pins_pkg::RL_IDLE;
					q_d.done = 1'b1;
				end
			end
		end
		// Without a detected ROM both lines stay released
		if (!enable)
		begin
			q_d.state = misc_pins_pkg::RL_IDLE;
			q_d.scl_oe = 1'b0;
			q_d.sda_oe = 1'b0;
			q_d.done = 1'b0;
		end
		q_d.busy = (q_d.state != misc_pins_pkg::RL_IDLE);
		if (srst)
			q_d = '0;
	end

	always_ff @(posedge clock)
		q_q <= q_d;

	assign busy = q_q.busy;
	assign done = q_q.done;
	assign rdata = q_q.rdata;
	assign ack_in = q_q.ack_in;
	assign scl_oe = q_q.scl_oe;
	assign sda_oe = q_q.sda_oe;

endmodule

`default_nettype wire

// ### bench/rom_model.sv
`timescale 1ns/10ps
`default_nettype none

module rom_model
(
	// Line levels
	input  wire logic       scl,
	input  wire logic       sda,
	// Read data
	input  wire logic       send,
	input  wire logic [7:0] rd_byte,
	output logic            sda_pull,
	output logic [7:0]      got
);
	int         cnt = 0;
	int         pos = 15;
	logic [7:0] sh  = 8'h00;

	initial got = 8'h00;
	// Start condition restarts the bit count
	always @(negedge sda)
		if (scl === 1'b1)
			cnt = 0;
	always @(posedge scl)
	begin
		sh = {sh[6:0], sda};
		cnt = cnt + 1;
		if (cnt == 8)
			got = sh;
	end
	// Changes only while the clock is low
	always @(negedge scl)
	begin
		if (cnt == 9)
			cnt = 0;
		pos = cnt;
	end
	// Acks writes; sends a byte when asked
	assign sda_pull = send ? (pos < 8 && !rd_byte[7 - pos]) : (pos == 8);
endmodule

`default_nettype wire

// ### bench/tb.sv
`timescale 1ns/10ps
`default_nettype none

module tb;
	logic       CLOCK = 1'b0, SRST = 1'b1, GLOBAL_RST = 1'b1;
	logic       CYCLE_SYNC_IN = 1'b0, CYCLE_EXT_SEL = 1'b0;
	logic       CYCLE_OUT_EN = 1'b1, CARD_MODE_STRAP_I = 1'b1;
	logic       GENERAL_IO_2_I = 1'b0, GENERAL_IO_3_I = 1'b0;
	logic       GENERAL_IO_2_DIR = 1'b1, GENERAL_IO_2_DATA = 1'b1;
	logic       GENERAL_IO_3_DIR = 1'b0, GENERAL_IO_3_DATA = 1'b0;
	logic       ROM_CMD_VALID = 1'b0, ROM_ACK_OUT = 1'b0;
	logic [1:0] ROM_CMD = 2'h0;
	logic [7:0] ROM_WDATA = 8'h00;
	logic       rom_fit = 1'b0, send = 1'b0;
	logic       CYCLE_TICK, CYCLE_SYNC_OUT_O, CYCLE_SYNC_OUT_OE, CARD_MODE;
	logic       GENERAL_IO_2_O, GENERAL_IO_2_OE, GENERAL_IO_2_LEVEL;
	logic       GENERAL_IO_3_O, GENERAL_IO_3_OE, GENERAL_IO_3_LEVEL;
	logic       SCL_O, SCL_OE, SDA_O, SDA_OE;
	logic       ROM_BUSY, ROM_DONE, ROM_ACK_IN, ROM_PRESENT;
	logic [7:0] ROM_RDATA, got;
	wire logic  scl_line, sda_line, rom_pull;
	int         mismatches = 0, checks_done = 0, n;

	// Pull-ups with a ROM fitted, pull-downs without
	assign scl_line = rom_fit ? ~SCL_OE : 1'b0;
	assign sda_line = rom_fit ? ~(SDA_OE | rom_pull) : 1'b0;

	always #2 CLOCK = ~CLOCK;
	initial
	begin
		#1.3;
		forever #80 CYCLE_SYNC_IN = ~CYCLE_SYNC_IN;
	end

	misc_pins #(.CYCLE_PERIOD(15'h0040)) u_misc_pins (.CLOCK(CLOCK),
		.SRST(SRST), .GLOBAL_RST(GLOBAL_RST), .CYCLE_SYNC_IN(CYCLE_SYNC_IN),
		.CYCLE_EXT_SEL(CYCLE_EXT_SEL), .CYCLE_OUT_EN(CYCLE_OUT_EN),
		.CYCLE_TICK(CYCLE_TICK), .CARD_MODE_STRAP_I(CARD_MODE_STRAP_I),
		.CYCLE_SYNC_OUT_O(CYCLE_SYNC_OUT_O), .CARD_MODE(CARD_MODE),
		.CYCLE_SYNC_OUT_OE(CYCLE_SYNC_OUT_OE),
		.GENERAL_IO_2_I(GENERAL_IO_2_I), .GENERAL_IO_2_O(GENERAL_IO_2_O),
		.GENERAL_IO_2_OE(GENERAL_IO_2_OE), .GENERAL_IO_2_DIR(GENERAL_IO_2_DIR),
		.GENERAL_IO_2_DATA(GENERAL_IO_2_DATA),
		.GENERAL_IO_2_LEVEL(GENERAL_IO_2_LEVEL),
		.GENERAL_IO_3_I(GENERAL_IO_3_I), .GENERAL_IO_3_O(GENERAL_IO_3_O),
		.GENERAL_IO_3_OE(GENERAL_IO_3_OE), .GENERAL_IO_3_DIR(GENERAL_IO_3_DIR),
		.GENERAL_IO_3_DATA(GENERAL_IO_3_DATA),
		.GENERAL_IO_3_LEVEL(GENERAL_IO_3_LEVEL),
		.SCL_O(SCL_O), .SCL_OE(SCL_OE), .SDA_I(sda_line), .SDA_O(SDA_O),
		.SDA_OE(SDA_OE), .ROM_CMD_VALID(ROM_CMD_VALID), .ROM_CMD(ROM_CMD),
		.ROM_WDATA(ROM_WDATA), .ROM_ACK_OUT(ROM_ACK_OUT), .ROM_BUSY(ROM_BUSY),
		.ROM_DONE(ROM_DONE), .ROM_RDATA(ROM_RDATA), .ROM_ACK_IN(ROM_ACK_IN),
		.ROM_PRESENT(ROM_PRESENT));

	rom_model u_rom_model (.scl(scl_line), .sda(sda_line), .send(send),
		.rd_byte(8'h3C), .sda_pull(rom_pull), .got(got));

	task step(input int k);
		repeat (k) @(posedge CLOCK);
		#1;
	endtask

	task chk(input logic [7:0] a, input logic [7:0] e);
		checks_done++;
		if (a !== e)
		begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, a, e);
		end
	endtask

	task print_verdict;
		$display("Checks %0d, mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Held past the 2-flop syncs so the strap and data line settle
	task do_reset(input logic strap, input logic fit);
		SRST = 1'b1;
		GLOBAL_RST = 1'b1;
		CARD_MODE_STRAP_I = strap;
		rom_fit = fit;
		step(4);
		chk({4'h0, GENERAL_IO_2_OE, GENERAL_IO_3_OE, SCL_OE, SDA_OE}, 8'h00);
		SRST = 1'b0;
		GLOBAL_RST = 1'b0;
		step(4);
	endtask

	task rom(input logic [1:0] c, input logic [7:0] d);
		int i;
		ROM_CMD = c;
		ROM_WDATA = d;
		ROM_CMD_VALID = 1'b1;
		step(1);
		ROM_CMD_VALID = 1'b0;
		chk({7'h00, ROM_BUSY}, 8'h01);
		for (i = 0; i < 30000 && ROM_DONE !== 1'b1; i++)
			step(1);
		chk({7'h00, ROM_DONE}, 8'h01);
	endtask

	// Cycles from one tick to the next
	task gap(output int k);
		int i;
		for (i = 0; i < 200 && CYCLE_TICK !== 1'b1; i++)
			step(1);
		step(1);
		k = 1;
		while (CYCLE_TICK !== 1'b1 && k < 200)
		begin
			step(1);
			k++;
		end
	endtask

	// Clock pin may only be pulled low
	always @(negedge CLOCK)
		if (SCL_OE === 1'b1)
			chk({6'h00, SCL_O, SDA_O}, 8'h00);

	initial
	begin
		do_reset(1'b0, 1'b0);
		chk({7'h00, CARD_MODE}, 8'h00);
		chk({7'h00, ROM_PRESENT}, 8'h00);
		chk({7'h00, CYCLE_SYNC_OUT_OE}, 8'h00);
		ROM_CMD_VALID = 1'b1;
		step(10);
		ROM_CMD_VALID = 1'b0;
		chk({5'h00, ROM_BUSY, SCL_OE, SDA_OE}, 8'h00);
		do_reset(1'b1, 1'b1);
		chk({6'h00, CARD_MODE, ROM_PRESENT}, 8'h03);
		chk({7'h00, CYCLE_SYNC_OUT_OE}, 8'h01);
		chk({5'h00, GENERAL_IO_2_OE, GENERAL_IO_2_O, GENERAL_IO_3_OE}, 8'h06);
		GENERAL_IO_2_I = 1'b1;
		step(3);
		chk({6'h00, GENERAL_IO_2_LEVEL, GENERAL_IO_3_LEVEL}, 8'h02);
		GENERAL_IO_3_DIR = 1'b1;
		GENERAL_IO_3_DATA = 1'b1;
		step(1);
		chk({6'h00, GENERAL_IO_3_OE, GENERAL_IO_3_O}, 8'h03);
		gap(n);
		chk(n[7:0], 8'h40);
		chk({7'h00, CYCLE_SYNC_OUT_O}, 8'h01);
		CYCLE_EXT_SEL = 1'b1;
		gap(n);
		gap(n);
		chk(n[7:0], 8'h28);
		CYCLE_EXT_SEL = 1'b0;
		rom(misc_pins_pkg::CMD_START, 8'h00);
		rom(misc_pins_pkg::CMD_WRITE, 8'hA5);
		chk(got, 8'hA5);
		chk({7'h00, ROM_ACK_IN}, 8'h01);
		send = 1'b1;
		rom(misc_pins_pkg::CMD_READ, 8'h00);
		chk(ROM_RDATA, 8'h3C);
		send = 1'b0;
		rom(misc_pins_pkg::CMD_STOP, 8'h00);
		chk({4'h0, SCL_O, SDA_O, SCL_OE, SDA_OE}, 8'h00);
		print_verdict;
	end

	initial
	begin
		#300000;
		mismatches++;
		print_verdict;
	end
endmodule

`default_nettype wire
